// >>> pkg/duart_defines.svh
// Purpose: Offsets, field positions, reset values and counts of one serial channel.
// Assumes: Three-bit register address, byte-wide data.
// Notes:   Definitions only.
`ifndef DUART_DEFINES_SVH
`define DUART_DEFINES_SVH
// Register addresses
`define ADDR_DATA          3'h0
`define ADDR_IRQ_EN        3'h1
`define ADDR_IRQ_STAT      3'h2
`define ADDR_LINE_CTRL     3'h3
`define ADDR_MODEM_CTRL    3'h4
`define ADDR_LINE_STAT     3'h5
`define ADDR_MODEM_STAT    3'h6
`define ADDR_SCRATCH       3'h7
// Bank selection values
`define ENH_BANK_KEY       8'hBF
`define DLAB_BIT           7
`define ENH_ENABLE_BIT     4
// Interrupt enable bit positions
`define IER_RX_DATA        0
`define IER_TX_EMPTY       1
`define IER_LINE_STAT      2
`define IER_MODEM_STAT     3
// FIFO control bit positions
`define FCR_ENABLE         0
`define FCR_RX_RESET       1
`define FCR_TX_RESET       2
`define FCR_DMA            3
// Interrupt source codes in status bits 3:0
`define ISR_NONE           4'h1
`define ISR_LINE           4'h6
`define ISR_RX_DATA        4'h4
`define ISR_TX_READY       4'h2
`define ISR_MODEM          4'h0
// Reset values
`define RST_BYTE           8'h00
`define RST_LINE_CTRL      8'h00
// FIFO depth and trigger levels
`define FIFO_DEPTH         32
`define RX_TRIG_L0         6'h01
`define RX_TRIG_L1         6'h08
`define RX_TRIG_L2         6'h10
`define RX_TRIG_L3         6'h1C
`define TX_TRIG_L0         6'h01
`define TX_TRIG_L1         6'h08
`define TX_TRIG_L2         6'h10
`define TX_TRIG_L3         6'h18
`endif

// >>> pkg/duart_pkg.sv
// Purpose: Types shared by the channel register block.
// Assumes: Nothing beyond the defines header.
// Notes:   Structs carry grouped signals.
package duart_pkg;
  typedef struct packed {
    logic       brk;
    logic       framing_err;
    logic       parity_err;
    logic [7:0] data;
  } rx_char_s;

  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } modem_in_s;

  typedef struct packed {
    logic [15:0] divisor;
    logic [7:0]  fractional;
    logic [7:0]  line_control;
    logic [7:0]  modem_control;
    logic [7:0]  enhanced;
    logic        fifo_enable;
    logic        dma_mode;
  } cfg_s;

  typedef struct packed {
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] pause_one;
    logic [7:0] pause_two;
  } flow_chars_s;
endpackage

// >>> rtl/sync_fifo.sv
// Purpose: Small synchronous FIFO with fill count.
// Assumes: Caller never pushes when full nor pops when empty.
// Notes:   Head word is read combinationally from the array.
`timescale 1ns/10ps
module sync_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 flush,
  input  wire logic                 push,
  input  wire logic [W-1:0]         din,
  input  wire logic                 pop,
  output logic      [W-1:0]         dout,
  output logic      [$clog2(D):0]   count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;

  // Pointer and count next values; flush wins over traffic
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end else begin
      if (push) wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop) cnt_d = cnt_q + 1'b1;
      else if (pop && !push) cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; count guards stale words
  always_ff @(posedge clk) begin
    if (push && !flush) mem[wr_q] <= din;
  end

  assign dout  = mem[rd_q];
  assign count = cnt_q;
endmodule // sync_fifo

// >>> rtl/change_detect.sv
// Purpose: One input level with a sticky change flag.
// Assumes: Input already synchronous to clk.
// Notes:   A change in the clearing cycle keeps the flag set.
`timescale 1ns/10ps
module change_detect #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level_in,
  input  wire logic clear,
  output logic      level_q,
  output logic      delta_q
);
  logic level_d, delta_d;

  // Set wins over clear
  always_comb begin
    level_d = level_in;
    delta_d = (level_in != level_q) | (delta_q & ~clear);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_q <= RESET_LEVEL;
      delta_q <= 1'b0;
    end else begin
      level_q <= level_d;
      delta_q <= delta_d;
    end
  end
endmodule // change_detect

// >>> rtl/duart_channel_regs.sv
// Purpose: Register file, FIFOs, status and interrupt logic of one serial channel.
// Assumes: Host strobes are one-cycle pulses synchronous to clk; serial shifters sit outside.
// Notes:   Read data appears one cycle after the read strobe.
// Functional notes
// - FIFO mode receive interrupt follows fill at or above trigger level.
// - Status bit 2 shows receive trigger condition, clear below it.
// - Data ready set on character entering FIFO, cleared when FIFO empty.
// - Clearing enable bits 0 to 3 gives polled use of line status.
// - Line status bit 1 flags a receive overrun.
// - Line status bits 2 to 4 give head character errors.
// - Line status bit 5 set while transmit holding is empty.
// - Line status bit 6 set when transmit FIFO and shifter empty.
// - Line status bit 7 set when any FIFO character has an error.
// - Enable bit 0 allows receive data interrupt, per FIFO mode.
// - Receive data interrupt enable resets to disabled; 1 enables it.
// - Enable register gates four interrupt sources shown in status register.
// - Enhanced IER, MCR and fraction fields act only while enhanced bit 4 is set.
// - Enabling transmit interrupt with holding empty raises it at once.
// - Status bit 0 reads 1 with nothing pending, 0 otherwise.
`timescale 1ns/10ps
`include "duart_defines.svh"
module duart_channel_regs #(
  parameter int         DEPTH     = `FIFO_DEPTH,
  parameter logic [7:0] REVISION  = 8'h01,  // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h5A   // Arbitrary value
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [2:0]             addr,
  input  wire logic                   rd_strobe,
  input  wire logic                   wr_strobe,
  input  wire logic [7:0]             wdata,
  output logic      [7:0]             rdata,
  input  wire logic                   rx_char_valid,
  input  wire duart_pkg::rx_char_s    rx_char,
  input  wire logic                   tx_pop,
  output logic      [7:0]             tx_byte,
  output logic                        tx_byte_valid,
  input  wire logic                   tsr_empty,
  input  wire duart_pkg::modem_in_s   modem_in,
  output logic                        irq,
  output duart_pkg::cfg_s             cfg,
  output duart_pkg::flow_chars_s      flow_chars
);
  localparam int CW = $clog2(DEPTH) + 1;

  // Control registers
  logic [7:0] lcr_q, lcr_d, ier_q, ier_d, mcr_q, mcr_d, efr_q, efr_d;
  logic [7:0] spr_q, spr_d, dll_q, dll_d, dlm_q, dlm_d, dld_q, dld_d;
  logic [1:0] rx_trig_q, rx_trig_d, tx_trig_q, tx_trig_d;
  logic       fifo_en_q, fifo_en_d, dma_q, dma_d;
  duart_pkg::flow_chars_s chars_q, chars_d;
  // Status state
  logic          overrun_q, overrun_d, txrdy_q, txrdy_d;
  logic [CW-1:0] err_cnt_q, err_cnt_d;
  logic [7:0]    rdata_q, rdata_d;

  // Bank and address decode
  logic enh_bank, dlab, enh_on, rd_rhr, wr_thr, rd_isr, rd_lsr, rd_msr, wr_fcr;
  assign enh_bank = (lcr_q == `ENH_BANK_KEY);
  assign dlab     = lcr_q[`DLAB_BIT];
  assign enh_on   = efr_q[`ENH_ENABLE_BIT];
  assign rd_rhr   = rd_strobe && !dlab && (addr == `ADDR_DATA);
  assign wr_thr   = wr_strobe && !dlab && (addr == `ADDR_DATA);
  assign rd_isr   = rd_strobe && !dlab && (addr == `ADDR_IRQ_STAT);
  assign wr_fcr   = wr_strobe && !dlab && (addr == `ADDR_IRQ_STAT);
  assign rd_lsr   = rd_strobe && !enh_bank && (addr == `ADDR_LINE_STAT);
  assign rd_msr   = rd_strobe && !enh_bank && (addr == `ADDR_MODEM_STAT);

  // Receive FIFO; in non-FIFO mode it holds one character
  duart_pkg::rx_char_s rx_head;
  logic [CW-1:0]       rx_count;
  logic                rx_full, rx_push, rx_pop, rx_flush, head_err;
  assign rx_full  = fifo_en_q ? (rx_count == CW'(DEPTH)) : (rx_count != '0);
  assign rx_push  = rx_char_valid && !rx_full;
  assign rx_pop   = rd_rhr && (rx_count != '0);
  assign head_err = rx_head.brk | rx_head.framing_err | rx_head.parity_err;
  // Changing FIFO mode flushes both sides so depth rules never disagree
  assign rx_flush = wr_fcr && ((wdata[`FCR_ENABLE] != fifo_en_q) ||
                               (wdata[`FCR_ENABLE] && wdata[`FCR_RX_RESET]));

  sync_fifo #(
    .W ($bits(duart_pkg::rx_char_s)),
    .D (DEPTH)
  ) rx_fifo (
    .clk   (clk),
    .rst   (rst),
    .flush (rx_flush),
    .push  (rx_push),
    .din   (rx_char),
    .pop   (rx_pop),
    .dout  (rx_head),
    .count (rx_count)
  );

  // Transmit FIFO; writes to a full holding register are dropped
  logic [CW-1:0] tx_count;
  logic          tx_full, tx_push, tx_flush, tx_empty;
  assign tx_empty = (tx_count == '0);
  assign tx_full  = fifo_en_q ? (tx_count == CW'(DEPTH)) : !tx_empty;
  assign tx_push  = wr_thr && !tx_full;
  assign tx_flush = wr_fcr && ((wdata[`FCR_ENABLE] != fifo_en_q) ||
                               (wdata[`FCR_ENABLE] && wdata[`FCR_TX_RESET]));

  sync_fifo #(
    .W (8),
    .D (DEPTH)
  ) tx_fifo (
    .clk   (clk),
    .rst   (rst),
    .flush (tx_flush),
    .push  (tx_push),
    .din   (wdata),
    .pop   (tx_pop && !tx_empty),
    .dout  (tx_byte),
    .count (tx_count)
  );
  assign tx_byte_valid = !tx_empty;

  // Modem inputs with change flags, cleared by a status read
  logic [3:0] modem_level, modem_delta;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_modem
      change_detect #(
        .RESET_LEVEL (1'b0)
      ) u_det (
        .clk      (clk),
        .rst      (rst),
        .level_in (modem_in[g]),
        .clear    (rd_msr),
        .level_q  (modem_level[g]),
        .delta_q  (modem_delta[g])
      );
    end
  endgenerate

  // Trigger levels
  logic [5:0] rx_trig_lvl, tx_trig_lvl;
  always_comb begin
    unique case (rx_trig_q)
      2'h0:    rx_trig_lvl = `RX_TRIG_L0;
      2'h1:    rx_trig_lvl = `RX_TRIG_L1;
      2'h2:    rx_trig_lvl = `RX_TRIG_L2;
      default: rx_trig_lvl = `RX_TRIG_L3;
    endcase
    unique case (tx_trig_q)
      2'h0:    tx_trig_lvl = `TX_TRIG_L0;
      2'h1:    tx_trig_lvl = `TX_TRIG_L1;
      2'h2:    tx_trig_lvl = `TX_TRIG_L2;
      default: tx_trig_lvl = `TX_TRIG_L3;
    endcase
  end

  // Line status assembly
  logic [7:0] line_status;
  always_comb begin
    line_status[0] = (rx_count != '0);
    line_status[1] = overrun_q;
    line_status[2] = line_status[0] & rx_head.parity_err;
    line_status[3] = line_status[0] & rx_head.framing_err;
    line_status[4] = line_status[0] & rx_head.brk;
    line_status[5] = tx_empty;
    line_status[6] = tx_empty & tsr_empty;
    line_status[7] = (err_cnt_q != '0);
  end

  // Interrupt sources and priority
  logic [7:0] ier_eff;
  logic       rx_rdy_cond, tx_cond, line_int, rx_int, tx_int, modem_int;
  logic [7:0] interrupt_status;
  assign ier_eff     = enh_on ? ier_q : {4'h0, ier_q[3:0]};
  assign rx_rdy_cond = fifo_en_q ? (rx_count >= CW'(rx_trig_lvl)) : (rx_count != '0);
  assign tx_cond     = fifo_en_q ? (tx_count < CW'(tx_trig_lvl)) : tx_empty;
  assign line_int    = ier_eff[`IER_LINE_STAT] & (|line_status[4:1]);
  assign rx_int      = ier_eff[`IER_RX_DATA] & rx_rdy_cond;
  assign tx_int      = ier_eff[`IER_TX_EMPTY] & txrdy_q;
  assign modem_int   = ier_eff[`IER_MODEM_STAT] & (|modem_delta);
  always_comb begin
    interrupt_status[7:4] = {fifo_en_q, fifo_en_q, 2'b00};
    if (line_int)       interrupt_status[3:0] = `ISR_LINE;
    else if (rx_int)    interrupt_status[3:0] = `ISR_RX_DATA;
    else if (tx_int)    interrupt_status[3:0] = `ISR_TX_READY;
    else if (modem_int) interrupt_status[3:0] = `ISR_MODEM;
    else                interrupt_status[3:0] = `ISR_NONE;
  end
  assign irq = !interrupt_status[0];

  // Control register writes
  always_comb begin
    lcr_d     = lcr_q;
    ier_d     = ier_q;
    mcr_d     = mcr_q;
    efr_d     = efr_q;
    spr_d     = spr_q;
    dll_d     = dll_q;
    dlm_d     = dlm_q;
    dld_d     = dld_q;
    chars_d   = chars_q;
    fifo_en_d = fifo_en_q;
    rx_trig_d = rx_trig_q;
    tx_trig_d = tx_trig_q;
    dma_d     = dma_q;
    if (wr_strobe) begin
      unique case (addr)
        `ADDR_DATA: begin
          if (dlab) dll_d = wdata;
        end
        `ADDR_IRQ_EN: begin
          if (dlab) dlm_d = wdata;
          else ier_d = enh_on ? wdata : {ier_q[7:4], wdata[3:0]};
        end
        `ADDR_IRQ_STAT: begin
          if (enh_bank) efr_d = wdata;
          else if (dlab && enh_on) dld_d = wdata;
          else if (!dlab) begin
            fifo_en_d = wdata[`FCR_ENABLE];
            if (wdata[`FCR_ENABLE]) begin
              rx_trig_d = wdata[7:6];
              dma_d     = wdata[`FCR_DMA];
              if (enh_on) tx_trig_d = wdata[5:4];
            end
          end
        end
        `ADDR_LINE_CTRL: lcr_d = wdata;
        `ADDR_MODEM_CTRL: begin
          if (enh_bank) chars_d.resume_one = wdata;
          else mcr_d = enh_on ? wdata : {mcr_q[7:5], wdata[4:0]};
        end
        `ADDR_LINE_STAT: begin
          if (enh_bank) chars_d.resume_two = wdata;
        end
        `ADDR_MODEM_STAT: begin
          if (enh_bank) chars_d.pause_one = wdata;
        end
        `ADDR_SCRATCH: begin
          if (enh_bank) chars_d.pause_two = wdata;
          else spr_d = wdata;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lcr_q     <= `RST_LINE_CTRL;
      ier_q     <= `RST_BYTE;
      mcr_q     <= `RST_BYTE;
      efr_q     <= `RST_BYTE;
      spr_q     <= `RST_BYTE;
      dll_q     <= `RST_BYTE;
      dlm_q     <= `RST_BYTE;
      dld_q     <= `RST_BYTE;
      chars_q   <= '0;
      fifo_en_q <= 1'b0;
      rx_trig_q <= 2'h0;
      tx_trig_q <= 2'h0;
      dma_q     <= 1'b0;
    end else begin
      lcr_q     <= lcr_d;
      ier_q     <= ier_d;
      mcr_q     <= mcr_d;
      efr_q     <= efr_d;
      spr_q     <= spr_d;
      dll_q     <= dll_d;
      dlm_q     <= dlm_d;
      dld_q     <= dld_d;
      chars_q   <= chars_d;
      fifo_en_q <= fifo_en_d;
      rx_trig_q <= rx_trig_d;
      tx_trig_q <= tx_trig_d;
      dma_q     <= dma_d;
    end
  end

  // Status flags; every set wins over its clearing access
  logic ier_tx_rise, tx_cond_q;
  assign ier_tx_rise = !ier_eff[`IER_TX_EMPTY] && ier_d[`IER_TX_EMPTY];
  always_comb begin
    overrun_d = (rx_char_valid & rx_full) | (overrun_q & ~rd_lsr);
    txrdy_d   = txrdy_q;
    if (wr_thr || (rd_isr && interrupt_status[3:0] == `ISR_TX_READY)) txrdy_d = 1'b0;
    if (tx_cond && !tx_cond_q) txrdy_d = 1'b1;
    if (ier_tx_rise && tx_cond) txrdy_d = 1'b1;
    // Error count tracks flagged characters inside the FIFO
    err_cnt_d = err_cnt_q;
    if (rx_flush) err_cnt_d = '0;
    else if ((rx_push && |rx_char[10:8]) && !(rx_pop && head_err)) err_cnt_d = err_cnt_q + 1'b1;
    else if (!(rx_push && |rx_char[10:8]) && (rx_pop && head_err)) err_cnt_d = err_cnt_q - 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overrun_q <= 1'b0;
      txrdy_q   <= 1'b0;
      tx_cond_q <= 1'b1;
      err_cnt_q <= '0;
    end else begin
      overrun_q <= overrun_d;
      txrdy_q   <= txrdy_d;
      tx_cond_q <= tx_cond;
      err_cnt_q <= err_cnt_d;
    end
  end

  // Read mux; identity codes show only with a zero divisor
  logic div_zero;
  assign div_zero = (dll_q == 8'h00) && (dlm_q == 8'h00);
  always_comb begin
    rdata_d = rdata_q;
    if (rd_strobe) begin
      unique case (addr)
        `ADDR_DATA:       rdata_d = dlab ? (div_zero ? REVISION : dll_q) : rx_head.data;
        `ADDR_IRQ_EN:     rdata_d = dlab ? ((div_zero && !enh_bank) ? DEVICE_ID : dlm_q) : ier_eff;
        `ADDR_IRQ_STAT:   rdata_d = enh_bank ? efr_q : (dlab ? (enh_on ? dld_q : 8'h00) : interrupt_status);
        `ADDR_LINE_CTRL:  rdata_d = lcr_q;
        `ADDR_MODEM_CTRL: rdata_d = enh_bank ? chars_q.resume_one : (enh_on ? mcr_q : {3'h0, mcr_q[4:0]});
        `ADDR_LINE_STAT:  rdata_d = enh_bank ? chars_q.resume_two : line_status;
        `ADDR_MODEM_STAT: rdata_d = enh_bank ? chars_q.pause_one : {modem_level, modem_delta};
        `ADDR_SCRATCH:    rdata_d = enh_bank ? chars_q.pause_two : spr_q;
      endcase
      if (rd_rhr && rx_count == '0) rdata_d = 8'h00;  // Empty receive reads zero
    end
  end

  always_ff @(posedge clk) begin
    if (rst) rdata_q <= 8'h00;
    else     rdata_q <= rdata_d;
  end
  assign rdata = rdata_q;

  // Configuration to the baud generator, shifters and flow control
  assign cfg.divisor       = {dlm_q, dll_q};
  assign cfg.fractional    = enh_on ? dld_q : 8'h00;
  assign cfg.line_control  = lcr_q;
  assign cfg.modem_control = enh_on ? mcr_q : {3'h0, mcr_q[4:0]};
  assign cfg.enhanced      = efr_q;
  assign cfg.fifo_enable   = fifo_en_q;
  assign cfg.dma_mode      = dma_q;
  assign flow_chars        = chars_q;
endmodule // duart_channel_regs

// >>> testbench/host_bus_model.sv
// Purpose: Host side of the parallel register bus.
// Assumes: Strobes are sampled on the rising edge; read data is settled one cycle later.
// Notes:   Drives at the falling edge; write data is scrambled once released.
`timescale 1ns/10ps
module host_bus_model (
  input  wire logic       clk,
  output logic      [2:0] addr,
  output logic            rd_strobe,
  output logic            wr_strobe,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr      = 3'h0;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    wdata     = 8'h00;
  end

  // One-cycle write, data inverted after release so stale values never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    addr      = a;
    wdata     = d;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    wdata     = ~d;
  endtask

  // One-cycle read, data taken once the answer has landed
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge clk);
    addr      = a;
    rd_strobe = 1'b1;
    @(negedge clk);
    rd_strobe = 1'b0;
    d         = rdata;
  endtask

  task automatic polled();
    wr(3'h1, 8'h00);
  endtask
endmodule // host_bus_model

// >>> testbench/duart_regs_monitor.sv
// Purpose: Port-level assertions for the channel register block.
// Assumes: Only the top module ports are visible.
// Notes:   Keeps a shadow of the low interrupt enables seen on the bus.
`timescale 1ns/10ps
module duart_regs_monitor (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic [2:0]           addr,
  input wire logic                 rd_strobe,
  input wire logic                 wr_strobe,
  input wire logic [7:0]           wdata,
  input wire logic [7:0]           rdata,
  input wire logic                 rx_char_valid,
  input wire logic [7:0]           tx_byte,
  input wire logic                 tx_byte_valid,
  input wire logic                 tsr_empty,
  input wire duart_pkg::modem_in_s modem_in,
  input wire logic                 irq,
  input wire duart_pkg::cfg_s      cfg,
  input wire logic                 tx_pop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [3:0] ier_q;
  logic [3:0] ier_d;
  logic       low_bank;
  logic       std_bank;

  // Bank decode as the host sees it
  assign low_bank = !cfg.line_control[7];
  assign std_bank = cfg.line_control != 8'hBF;

  // Shadow enables; upper bits ignored since they gate nothing here
  always_comb begin
    ier_d = ier_q;
    if (wr_strobe && addr == 3'h1 && low_bank) begin
      ier_d = wdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ier_q <= 4'h0;
    end else begin
      ier_q <= ier_d;
    end
  end

  AST_POLLED_QUIET: assert property (ier_q == 4'h0 |-> !irq)
    else $error("irq raised with all enables clear");
  AST_TX_IMMEDIATE: assert property (wr_strobe && addr == 3'h1 && low_bank && wdata[1] && !ier_q[1]
    && !tx_byte_valid |=> irq) else $error("transmit ready not raised at enable");
  AST_RX_NONFIFO: assert property (rx_char_valid && ier_q[0] && !cfg.fifo_enable && !wr_strobe
    && !rd_strobe |=> irq) else $error("receive interrupt missing in non-fifo mode");
  AST_THR_PUSH: assert property (wr_strobe && addr == 3'h0 && low_bank && !tx_byte_valid && !tx_pop
    |=> tx_byte_valid && tx_byte == $past(wdata)) else $error("holding write not taken");
  AST_LSR_THRE: assert property (rd_strobe && addr == 3'h5 && std_bank
    |=> rdata[5] == !$past(tx_byte_valid)) else $error("holding empty bit wrong");
  AST_LSR_TEMT: assert property (rd_strobe && addr == 3'h5 && std_bank
    |=> rdata[6] == $past(!tx_byte_valid && tsr_empty)) else $error("transmitter empty bit wrong");
  AST_ISR_READ: assert property (rd_strobe && addr == 3'h2 && low_bank
    |=> rdata[0] == !$past(irq) && rdata[7:6] == {2{$past(cfg.fifo_enable)}}) else $error("status read wrong");
  AST_MSR_LEVELS: assert property (rd_strobe && addr == 3'h6 && std_bank && $stable(modem_in)
    && !$past(rst) |=> rdata[7:4] == $past(modem_in)) else $error("modem levels wrong");
  AST_DLD_GATED: assert property (wr_strobe && addr == 3'h2 && !low_bank && std_bank
    && !cfg.enhanced[4] |=> cfg.fractional == 8'h00) else $error("fraction taken while gated");
endmodule // duart_regs_monitor

bind duart_channel_regs duart_regs_monitor mon_u (.clk(clk), .rst(rst), .addr(addr), .rd_strobe(rd_strobe),
  .wr_strobe(wr_strobe), .wdata(wdata), .rdata(rdata), .rx_char_valid(rx_char_valid), .tx_byte(tx_byte),
  .tx_byte_valid(tx_byte_valid), .tsr_empty(tsr_empty), .modem_in(modem_in), .irq(irq), .cfg(cfg),
  .tx_pop(tx_pop));

// >>> testbench/duart_irq_enable_line_status_test.sv
// Purpose: Self-checking bench for the channel register block.
// Assumes: Default trigger tables, revision 01 and device code 5A (arbitrary).
// Notes:   Inputs change at the falling edge; random data from a fixed seed.
`timescale 1ns/10ps
module duart_irq_enable_line_status_test;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    rx_char_valid = 1'b0;
  duart_pkg::rx_char_s     rx_char = '0;
  logic                    tx_pop = 1'b0;
  logic                    tsr_empty = 1'b1;
  duart_pkg::modem_in_s    modem_in = '0;
  logic [2:0]              addr;
  logic                    rd_strobe;
  logic                    wr_strobe;
  logic [7:0]              wdata;
  logic [7:0]              rdata;
  logic [7:0]              tx_byte;
  logic                    tx_byte_valid;
  logic                    irq;
  duart_pkg::cfg_s         cfg;
  duart_pkg::flow_chars_s  flow_chars;
  int                      error_cnt = 0;
  int                      total_checks = 0;
  logic [7:0]              rq[$];
  logic [7:0]              v;
  logic [7:0]              d;
  logic [3:0]              m;

  always #4 clk = ~clk;

  duart_channel_regs dut_u (.clk(clk), .rst(rst), .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .wdata(wdata), .rdata(rdata), .rx_char_valid(rx_char_valid), .rx_char(rx_char), .tx_pop(tx_pop),
    .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid), .tsr_empty(tsr_empty), .modem_in(modem_in),
    .irq(irq), .cfg(cfg), .flow_chars(flow_chars));

  host_bus_model host_u (.clk(clk), .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .wdata(wdata), .rdata(rdata));

  // Byte comparison, counted
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string s);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  // Read a register and compare
  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string s);
    host_u.rd(a, v);
    chk(v, e, s);
  endtask

  // Receiver hands over one character; model queue follows
  task automatic push(input logic [2:0] f);
    @(negedge clk);
    rx_char_valid = 1'b1;
    rx_char       = {f, 8'($urandom)};
    rq.push_back(rx_char.data);
    @(negedge clk);
    rx_char_valid = 1'b0;
  endtask

  // Expected status byte from fifo mode and source code
  function automatic logic [7:0] isr_exp(input logic f, input logic [3:0] c);
    return {f, f, 2'b00, c};
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    $display("ERROR t=%0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    void'($urandom(68));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdc(3'h2, isr_exp(1'b0, 4'h1), "isr reset");
    rdc(3'h5, 8'h60, "lsr reset");
    rdc(3'h1, 8'h00, "ier reset");
    $display("test reset done");

    // Register banks, ids, gated fraction, flow characters
    d = 8'($urandom);
    host_u.wr(3'h7, d);
    rdc(3'h7, d, "scratch");
    host_u.wr(3'h3, 8'h80);
    rdc(3'h0, 8'h01, "revision");
    rdc(3'h1, 8'h5A, "device id");
    host_u.wr(3'h2, 8'h0F);
    rdc(3'h2, 8'h00, "fraction gated");
    d = 8'($urandom) | 8'h01;
    host_u.wr(3'h0, d);
    chk(cfg.divisor[7:0], d, "divisor low");
    host_u.wr(3'h3, 8'hBF);
    host_u.wr(3'h2, 8'h10);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      host_u.wr(3'(4 + i), d);
      chk(flow_chars[31 - 8 * i -: 8], d, "flow char");
    end
    host_u.wr(3'h3, 8'h80);
    host_u.wr(3'h2, 8'h0A);
    rdc(3'h2, 8'h0A, "fraction open");
    host_u.wr(3'h3, 8'hBF);
    host_u.wr(3'h2, 8'h00);
    host_u.wr(3'h3, 8'h00);
    $display("test banks done");

    // Receive trigger at 8, polled use, error flags
    host_u.wr(3'h2, 8'h41);
    host_u.wr(3'h1, 8'h01);
    repeat (7) push(3'h0);
    chk({7'h0, irq}, 8'h00, "below trigger");
    push(3'h0);
    chk({7'h0, irq}, 8'h01, "at trigger");
    rdc(3'h2, isr_exp(1'b1, 4'h4), "isr trigger");
    rdc(3'h5, 8'h61, "data ready");
    rdc(3'h0, rq.pop_front(), "rhr data");
    chk({7'h0, irq}, 8'h00, "dropped below");
    rdc(3'h2, isr_exp(1'b1, 4'h1), "isr cleared");
    host_u.polled();
    push(3'h0);
    chk({7'h0, irq}, 8'h00, "polled no irq");
    rdc(3'h5, 8'h61, "polled status");
    push(3'h1);
    rdc(3'h5, 8'hE1, "error in fifo");
    while (rq.size() > 0) begin
      if (rq.size() == 1) begin
        rdc(3'h5, 8'hE5, "head parity");
      end
      rdc(3'h0, rq.pop_front(), "drain data");
    end
    rdc(3'h5, 8'h60, "fifo empty");
    $display("test fifo receive done");

    // Non-fifo overrun
    host_u.wr(3'h2, 8'h00);
    host_u.wr(3'h1, 8'h05);
    push(3'h0);
    push(3'h0);
    chk({7'h0, irq}, 8'h01, "holding full irq");
    rdc(3'h2, isr_exp(1'b0, 4'h6), "isr line");
    rdc(3'h5, 8'h63, "overrun");
    rdc(3'h2, isr_exp(1'b0, 4'h4), "isr rx");
    rdc(3'h0, rq.pop_front(), "kept char");
    void'(rq.pop_front());
    rdc(3'h5, 8'h60, "overrun cleared");
    host_u.wr(3'h1, 8'h00);
    $display("test overrun done");

    // Transmit ready and empty flags
    host_u.wr(3'h2, 8'h01);
    host_u.wr(3'h1, 8'h02);
    chk({7'h0, irq}, 8'h01, "tx ready at once");
    rdc(3'h2, isr_exp(1'b1, 4'h2), "isr tx");
    chk({7'h0, irq}, 8'h00, "tx cleared by read");
    d = 8'($urandom);
    host_u.wr(3'h0, d);
    chk(tx_byte, d, "tx head");
    tsr_empty = 1'b0;
    rdc(3'h5, 8'h00, "holding busy");
    @(negedge clk);
    tx_pop = 1'b1;
    @(negedge clk);
    tx_pop = 1'b0;
    @(negedge clk);
    chk({7'h0, irq}, 8'h01, "tx ready again");
    rdc(3'h5, 8'h20, "shifter busy");
    tsr_empty = 1'b1;
    rdc(3'h5, 8'h60, "all empty");
    $display("test transmit done");

    // Modem levels and change flags
    host_u.wr(3'h1, 8'h08);
    m = 4'($urandom) | 4'h1;
    modem_in = m;
    repeat (2) @(negedge clk);
    chk({7'h0, irq}, 8'h01, "modem irq");
    rdc(3'h6, {m, m}, "modem change");
    rdc(3'h6, {m, 4'h0}, "deltas cleared");
    chk({7'h0, irq}, 8'h00, "modem irq gone");
    $display("test modem done");
    report_and_stop();
  end
endmodule // duart_irq_enable_line_status_test
